// ### design/jemp_pkg.sv
// jemp_pkg: shared types and constants for the test-access and emulation pin block
package jemp_pkg;
	localparam int JEMP_IR_LEN = 4;
	localparam int JEMP_DR_LEN = 8;
	localparam logic [3:0] JEMP_IR_RESET = 4'h1;
	localparam logic [3:0] JEMP_IR_EMU_DIR = 4'h5;
	localparam logic [1:0] JEMP_DIR_RESET = 2'h0;
	localparam logic [1:0] JEMP_EMU_BSCAN = 2'h1;
	localparam logic [1:0] JEMP_EMU_WAIT = 2'h2;
	localparam int JEMP_DIR_POS = 0;
	localparam int JEMP_DRV_POS = 2;

	// tap controller states
	typedef enum logic [3:0] {
		JEMP_TLR = 4'h0,
		JEMP_RTI = 4'h1,
		JEMP_SEL_DR = 4'h2,
		JEMP_CAP_DR = 4'h3,
		JEMP_SH_DR = 4'h4,
		JEMP_EX1_DR = 4'h5,
		JEMP_PA_DR = 4'h6,
		JEMP_EX2_DR = 4'h7,
		JEMP_UPD_DR = 4'h8,
		JEMP_SEL_IR = 4'h9,
		JEMP_CAP_IR = 4'hA,
		JEMP_SH_IR = 4'hB,
		JEMP_EX1_IR = 4'hC,
		JEMP_PA_IR = 4'hD,
		JEMP_EX2_IR = 4'hE,
		JEMP_UPD_IR = 4'hF
	} jemp_tap_t;

	// emulation pin group: input, output and output enable (low = driving)
	typedef struct packed {
		logic [1:0] pin_in;
		logic [1:0] pin_out;
		logic [1:0] pin_oe_b;
	} jemp_emu_t;

	// mode flags handed to the system side
	typedef struct packed {
		logic bscan;
		logic wait_in_reset_mode;
		logic boot_go;
	} jemp_mode_t;
endpackage : jemp_pkg

// ### design/jemp_top.sv
// jemp_top: serial test port, emulation pins and reset-exit mode selection
//
// Overview of operation
// - test data input captured into selected register on test clock rising edge
// - selected register shifted out on test data output at falling edge
// - with test reset high, emulation pins act as two-way interrupt lines
// - pin zero high, pin one low at test reset rise latches boundary scan
// - pin zero low, pin one high at reset exit enters wait-in-reset mode
// - wait-in-reset holds off bootloader so probe can reprogram flash
// - test reset low keeps functional mode and ignores test signalling
// - test mode select sampled into tap controller on test clock rising edge
`timescale 1ns/1ps
`default_nettype none
module jemp_top
	import jemp_pkg::*;
(
	// system side
	input wire logic clk_sys,
	input wire logic rst_b,
	// test port, clocked by the probe
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_b,
	// emulation pins
	input wire logic [1:0] emu_in,
	output logic [1:0] emu_out,
	output logic [1:0] emu_oe_b,
	// interrupt lines to and from the system
	input wire logic [1:0] sys_irq_out,
	output logic [1:0] sys_irq_in,
	// mode results
	output logic bscan_mode,
	output logic wait_in_reset_mode,
	output logic boot_go
);
	////////////////////////////////////////////////////////////////////////////
	// tap controller, test clock domain
	jemp_tap_t tap;
	jemp_tap_t next_tap;
	logic [JEMP_IR_LEN-1:0] ir_sh;
	logic [JEMP_IR_LEN-1:0] ir;
	logic [JEMP_DR_LEN-1:0] dr_sh;
	logic [3:0] emu_cfg;
	logic bypass;
	logic tdo_q;
	logic bscan_tck;

	always_comb begin
		next_tap = tap;
		unique case (tap)
			JEMP_TLR: next_tap = tms ? JEMP_TLR : JEMP_RTI;
			JEMP_RTI: next_tap = tms ? JEMP_SEL_DR : JEMP_RTI;
			JEMP_SEL_DR: next_tap = tms ? JEMP_SEL_IR : JEMP_CAP_DR;
			JEMP_CAP_DR: next_tap = tms ? JEMP_EX1_DR : JEMP_SH_DR;
			JEMP_SH_DR: next_tap = tms ? JEMP_EX1_DR : JEMP_SH_DR;
			JEMP_EX1_DR: next_tap = tms ? JEMP_UPD_DR : JEMP_PA_DR;
			JEMP_PA_DR: next_tap = tms ? JEMP_EX2_DR : JEMP_PA_DR;
			JEMP_EX2_DR: next_tap = tms ? JEMP_UPD_DR : JEMP_SH_DR;
			JEMP_UPD_DR: next_tap = tms ? JEMP_SEL_DR : JEMP_RTI;
			JEMP_SEL_IR: next_tap = tms ? JEMP_TLR : JEMP_CAP_IR;
			JEMP_CAP_IR: next_tap = tms ? JEMP_EX1_IR : JEMP_SH_IR;
			JEMP_SH_IR: next_tap = tms ? JEMP_EX1_IR : JEMP_SH_IR;
			JEMP_EX1_IR: next_tap = tms ? JEMP_UPD_IR : JEMP_PA_IR;
			JEMP_PA_IR: next_tap = tms ? JEMP_EX2_IR : JEMP_PA_IR;
			JEMP_EX2_IR: next_tap = tms ? JEMP_UPD_IR : JEMP_SH_IR;
			JEMP_UPD_IR: next_tap = tms ? JEMP_SEL_DR : JEMP_RTI;
		endcase
	end

	wire sel_emu = (ir == JEMP_IR_EMU_DIR);
	wire sh_dr = (tap == JEMP_SH_DR);
	wire sh_ir = (tap == JEMP_SH_IR);
	wire [JEMP_DR_LEN-1:0] cap_dr = {4'h0, emu_cfg};
	wire serial_bit = sh_ir ? ir_sh[0] : (sel_emu ? dr_sh[0] : bypass);

	// test reset low holds the port in reset, ignoring the probe
	always_ff @(posedge tck or negedge trst_b) begin
		if (!trst_b) begin
			tap <= JEMP_TLR;
			ir_sh <= JEMP_IR_RESET;
			ir <= JEMP_IR_RESET;
			dr_sh <= '0;
			bypass <= 1'b0;
			emu_cfg <= 4'h0;
		end else begin
			tap <= next_tap;
			// capture serial data into selected register
			if (tap == JEMP_CAP_IR) ir_sh <= JEMP_IR_RESET;
			else if (sh_ir) ir_sh <= {tdi, ir_sh[JEMP_IR_LEN-1:1]};
			if (tap == JEMP_UPD_IR) ir <= ir_sh;
			else if (tap == JEMP_TLR) ir <= JEMP_IR_RESET;
			if (tap == JEMP_CAP_DR) dr_sh <= cap_dr;
			else if (sh_dr && sel_emu) dr_sh <= {tdi, dr_sh[JEMP_DR_LEN-1:1]};
			// bypass captures zero so the first bit out is known
			if (tap == JEMP_CAP_DR) bypass <= 1'b0;
			else if (sh_dr) bypass <= tdi;
			// pin direction and drive level set through the scan
			if (tap == JEMP_UPD_DR && sel_emu) emu_cfg <= dr_sh[3:0];
		end
	end

	always_ff @(negedge tck or negedge trst_b) begin
		if (!trst_b) begin
			tdo_q <= 1'b0;
			tdo_oe_b <= 1'b1;
		end else begin
			tdo_q <= serial_bit;
			// enable flop feeds the pad directly, no gate after it
			tdo_oe_b <= ~(sh_ir | sh_dr);
		end
	end
	assign tdo = tdo_q;

	// latch boundary scan on rising edge of test reset
	always_ff @(posedge trst_b) begin
		bscan_tck <= (emu_in == JEMP_EMU_BSCAN);
	end

	////////////////////////////////////////////////////////////////////////////
	// emulation pins: direction bits 1:0, drive levels bits 3:2
	// config word crosses into the system clock; it is taken only once two
	// successive samples agree, so a half-moved word never reaches the pins
	logic [3:0] cfg_s1;
	logic [3:0] cfg_s2;
	logic [3:0] cfg_s3;
	logic [3:0] cfg_sys;
	wire [1:0] emu_dir = cfg_sys[JEMP_DRV_POS-1:JEMP_DIR_POS];
	wire [1:0] emu_lvl = cfg_sys[JEMP_DRV_POS+1:JEMP_DRV_POS] | sys_irq_out;

	////////////////////////////////////////////////////////////////////////////
	// system domain: synchronisers and reset-exit decision
	logic [1:0] emu_s1, emu_s2, trst_s1, trst_s2;
	logic [1:0] bs_s;
	logic decided;
	always_ff @(posedge clk_sys) begin
		emu_s1 <= emu_in;
		emu_s2 <= emu_s1;
		trst_s1 <= {trst_s1[0], trst_b};
		trst_s2 <= {trst_s2[0], trst_s1[1]};
		bs_s <= {bs_s[0], bscan_tck & trst_b};
		cfg_s1 <= emu_cfg;
		cfg_s2 <= cfg_s1;
		cfg_s3 <= cfg_s2;
	end

	// drive only while test reset is high and the bit selects output
	// test reset low releases the pins at once, without waiting for a clock
	always_ff @(posedge clk_sys or negedge trst_b) begin
		if (!trst_b) begin
			emu_oe_b <= 2'h3;
		end else if (!rst_b) begin
			emu_oe_b <= 2'h3;
		end else begin
			emu_oe_b <= ~(emu_dir & {2{trst_s2[1]}});
		end
	end

	wire pin_wait = (emu_s2 == JEMP_EMU_WAIT);
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			decided <= 1'b0;
			wait_in_reset_mode <= 1'b0;
			boot_go <= 1'b0;
			bscan_mode <= 1'b0;
			sys_irq_in <= 2'h0;
			cfg_sys <= 4'h0;
			emu_out <= 2'h0;
		end else begin
			bscan_mode <= bs_s[1];
			if (cfg_s2 == cfg_s3) cfg_sys <= cfg_s2;
			emu_out <= emu_lvl;
			// probe interrupts reach the system only with test reset high
			sys_irq_in <= emu_s2 & ~emu_dir & {2{trst_s2[1]}};
			if (!decided) begin
				decided <= 1'b1;
				// sample pins as reset is left
				wait_in_reset_mode <= pin_wait;
				// boot only without a special combination
				boot_go <= !pin_wait && !bs_s[1];
			end
		end
	end

	a_wait_no_boot: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wait_in_reset_mode |-> !boot_go) else $error("boot while waiting");
	a_wait_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(wait_in_reset_mode) |-> ##1 wait_in_reset_mode[*3]) else $error("wait lost");
	a_boot_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		boot_go |=> boot_go) else $error("boot dropped");
	// pins float with test reset low
	a_emu_float: assert property (@(posedge clk_sys)
		!trst_b |-> emu_oe_b == 2'h3) else $error("pin driven in reset");
	a_tap_reset: assert property (@(posedge tck)
		!trst_b |-> tap == JEMP_TLR) else $error("tap not reset");
	a_tms_reset: assert property (@(posedge tck) disable iff (!trst_b)
		tms[*5] |=> tap == JEMP_TLR) else $error("tms reset failed");
	a_ir_shift: assert property (@(posedge tck) disable iff (!trst_b)
		sh_ir |=> ir_sh[JEMP_IR_LEN-1] == $past(tdi)) else $error("tdi not captured");
	a_tdo_follow: assert property (@(negedge tck) disable iff (!trst_b)
		1'b1 |=> tdo_q == $past(serial_bit)) else $error("tdo wrong");
	// probe interrupts blocked while test reset is low
	a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!trst_s2[1] |=> sys_irq_in == 2'h0) else $error("interrupt passed in reset");
	a_tdo_quiet: assert property (@(negedge tck) disable iff (!trst_b)
		!(sh_ir || sh_dr) |=> tdo_oe_b) else $error("output enabled outside shift");
	// boundary scan flag follows the latched pins
	a_bscan_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
		bs_s[1] |=> bscan_mode) else $error("boundary scan not flagged");
endmodule : jemp_top
`default_nettype wire

// ### tb/jemp_probe.sv
// jemp_probe: debug probe model for the test port and emulation pins
`timescale 1ns/1ps
`default_nettype none
module jemp_probe (
	// test port
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	// emulation pins
	input wire logic [1:0] emu_out,
	input wire logic [1:0] emu_oe_b,
	output logic [1:0] emu_in
);
	logic [1:0] drv_en = 2'h0;
	logic [1:0] drv_val = 2'h0;
	// pulled-up pins, the device drive wins
	assign emu_in = ~emu_oe_b & emu_out | emu_oe_b & (drv_en & drv_val | ~drv_en);
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end
	// test clock only runs inside frames
	task automatic step(input logic m, input logic d, output logic o);
		o = tdo;
		tms = m;
		tdi = d;
		#6 tck = 1'h1;
		#6 tck = 1'h0;
		#1;
	endtask : step
	task automatic scan(input logic ir, input int n, input logic [7:0] d, output logic [7:0] q);
		logic o;
		q = 8'h00;
		step(1'h1, 1'h0, o);
		if (ir) begin
			step(1'h1, 1'h0, o);
		end
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], o);
			q[i] = o;
		end
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask : scan
endmodule : jemp_probe
`default_nettype wire

// ### tb/test_jemp_top.sv
// test_jemp_top: self-checking bench for the test port and emulation pins
`timescale 1ns/1ps
`default_nettype none
module test_jemp_top;
	import jemp_pkg::*;
	logic clk_sys = 1'h0;
	logic rst_b = 1'h0;
	logic trst_b = 1'h1;
	logic [1:0] sys_irq_out = 2'h0;
	wire tck, tms, tdi, tdo, tdo_oe_b, bscan_mode, wait_in_reset_mode, boot_go;
	wire [1:0] emu_in, emu_out, emu_oe_b, sys_irq_in;
	logic [7:0] q = 8'h00;
	logic [7:0] d;
	integer seed = 93814;
	int err_total = 0;
	int num_checks = 0;
	logic [35:0] exp_q[$];
	logic [35:0] e;
	event look;
	always #5 clk_sys = ~clk_sys;
	jemp_top uut (.clk_sys, .rst_b, .tck, .trst_b, .tms, .tdi, .tdo, .tdo_oe_b, .emu_in,
		.emu_out, .emu_oe_b, .sys_irq_out, .sys_irq_in, .bscan_mode, .wait_in_reset_mode,
		.boot_go);
	jemp_probe probe (.tck, .tms, .tdi, .tdo, .emu_out, .emu_oe_b, .emu_in);
	wire [17:0] obs = {q, bscan_mode, wait_in_reset_mode, boot_go, tdo_oe_b, emu_oe_b,
		emu_out, sys_irq_in};
	task check(input logic [17:0] got, input logic [17:0] want);
		num_checks++;
		if (got !== want) begin
			err_total++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask : check
	// expected value goes on the queue, the monitor compares it
	task note(input logic [17:0] m, input logic [17:0] v);
		exp_q.push_back({m, v});
		-> look;
		#1;
	endtask : note
	always @(look) begin
		e = exp_q.pop_front();
		check(obs & e[35:18], e[17:0]);
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
	initial begin
		probe.drv_en = 2'h3;
		probe.drv_val = 2'h2;
		// a real falling edge so the async test reset is seen
		#1 trst_b = 1'h0;
		cyc(5);
		rst_b = 1'h1;
		cyc(4);
		note(18'h003F0, 18'h00170);
		$display("wait mode test done");
		rst_b = 1'h0;
		probe.drv_en = 2'h0;
		cyc(5);
		rst_b = 1'h1;
		cyc(4);
		note(18'h003F0, 18'h000F0);
		$display("normal boot test done");
		probe.drv_en = 2'h3;
		probe.drv_val = 2'h1;
		cyc(3);
		trst_b = 1'h1;
		cyc(4);
		note(18'h00200, 18'h00200);
		$display("boundary scan test done");
		probe.drv_en = 2'h0;
		probe.step(1'h0, 1'h0, q[0]);
		probe.scan(1'h1, 4, 8'h03, q);
		d = 8'($random(seed));
		probe.scan(1'h0, 8, d, q);
		note(18'h3FC00, {d[6:0], 1'h0, 10'h000});
		$display("bypass test done");
		probe.scan(1'h1, 4, {4'h0, JEMP_IR_EMU_DIR}, q);
		probe.scan(1'h0, 8, 8'h01, q);
		cyc(1);
		d = 8'($random(seed));
		sys_irq_out = d[1:0];
		probe.drv_en = 2'h2;
		probe.drv_val = {d[2], 1'h0};
		cyc(6);
		note(18'h00036, {12'h000, 2'h2, 1'h0, d[0], d[2], 1'h0});
		$display("interrupt line test done");
		trst_b = 1'h0;
		cyc(2);
		note(18'h00070, 18'h00070);
		$display("test reset test done");
		report_and_stop;
	end
endmodule : test_jemp_top
`default_nettype wire
